// ### rtl/fes_host.sv
// Purpose: host controller issuing erase, suspend and resume sequences to a flash
// Assumes: Wishbone classic slave for software, flash pins synchronous to clk
// Notes: reset aborts any sequence; the flash reset pin is pulsed from here
//
// The address map and register access over Wishbone were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "fes_cfg.svh"
// Operation
// - chip erase is six write cycles
// - hardware reset aborts erase, reissue afterward
// - sector erase is six cycles ending 30h
// - host spaces added sectors under 50 us
// - window allows only 30h, b0h, f0h
// - suspend b0h at selected bank address
// - resume with bank address restarts erase
// - resume is one cycle, code 30h
module fes_host import fes_pkg::*; #(
    parameter int unsigned WINDOW_CYC = `FES_WINDOW_CYC,
    parameter int unsigned SUSPEND_CYC = `FES_SUSPEND_CYC
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic [`FES_ADDR_W-1:0] flash_addr,
    input wire logic [7:0] flash_dq_i,
    output logic [7:0] flash_dq_o,
    output logic flash_dq_oe,
    output logic flash_we_n,
    output logic flash_oe_n,
    output logic flash_ce_n,
    output logic flash_reset_n,
    input wire logic ready_busy_output
);
    // registers: 0 cmd (w), 1 addr, 2 status (r), 3 last read data
    typedef enum logic [2:0] {H_IDLE, H_ISSUE, H_WAIT, H_WIN, H_SUSP, H_RST} fes_hst_t;
    typedef struct packed {
        fes_hst_t st;
        fes_op_t op;
        logic [2:0] step;
        logic [`FES_ADDR_W-1:0] addr;
        logic [7:0] rdata;
        logic [31:0] timer;
        logic win_open;
        logic chip_busy;
        logic sect_busy;
        logic suspended;
        logic refused;
        logic start;
        logic ack;
        logic [31:0] dat;
        logic rst_pin;
    } fes_h_t;
    fes_h_t s_q, s_d;

    logic bc_done;
    logic [7:0] bc_rdata;
    logic [`FES_ADDR_W-1:0] cyc_addr;
    logic [7:0] cyc_data;
    logic bc_write;

    function automatic logic [`FES_ADDR_W-1:0] bank_base(input logic [`FES_ADDR_W-1:0] a);
        bank_base = a & ~((`FES_ADDR_W'(1) << `FES_BANK_LSB) - `FES_ADDR_W'(1));
    endfunction

    function automatic logic [`FES_ADDR_W-1:0] sector_base(input logic [`FES_ADDR_W-1:0] a);
        sector_base = a & ~((`FES_ADDR_W'(1) << `FES_SECTOR_LSB) - `FES_ADDR_W'(1));
    endfunction

    // sequence table: unlock, unlock, setup, unlock, unlock, final
    always_comb begin
        cyc_addr = s_q.addr;
        cyc_data = 8'h00;
        bc_write = (s_q.op != FES_OP_READ);
        case (s_q.op)
            FES_OP_CHIP, FES_OP_SECTOR: begin
                case (s_q.step)
                    3'd0, 3'd3: begin
                        cyc_addr = `FES_UNLOCK1_ADDR;
                        cyc_data = `FES_UNLOCK1_DATA;
                    end
                    3'd1, 3'd4: begin
                        cyc_addr = `FES_UNLOCK2_ADDR;
                        cyc_data = `FES_UNLOCK2_DATA;
                    end
                    3'd2: begin
                        cyc_addr = `FES_UNLOCK1_ADDR;
                        cyc_data = `FES_SETUP_DATA;
                    end
                    default: begin
                        cyc_addr = (s_q.op == FES_OP_CHIP) ? `FES_UNLOCK1_ADDR
                                                            : sector_base(s_q.addr);
                        cyc_data = (s_q.op == FES_OP_CHIP) ? `FES_CHIP_ERASE_DATA
                                                            : `FES_SECTOR_ERASE_DATA;
                    end
                endcase
            end
            FES_OP_ADD_SECTOR: begin
                cyc_addr = sector_base(s_q.addr);
                cyc_data = `FES_SECTOR_ERASE_DATA;
            end
            FES_OP_SUSPEND: begin
                cyc_addr = bank_base(s_q.addr);
                cyc_data = `FES_SUSPEND_DATA;
            end
            FES_OP_RESUME: begin
                cyc_addr = bank_base(s_q.addr);
                cyc_data = `FES_RESUME_DATA;
            end
            FES_OP_RESET: begin
                cyc_data = `FES_RESET_DATA;
            end
            default: begin
                cyc_data = 8'h00;
            end
        endcase
    end

    fes_bus_cycle u_cycle (
        .clk(clk),
        .rst_n(rst_n),
        .start(s_q.start),
        .write(bc_write),
        .addr(cyc_addr),
        .wdata(cyc_data),
        .dq_in(flash_dq_i),
        .flash_addr(flash_addr),
        .dq_out(flash_dq_o),
        .dq_oe(flash_dq_oe),
        .we_n(flash_we_n),
        .oe_n(flash_oe_n),
        .ce_n(flash_ce_n),
        .done(bc_done),
        .rdata(bc_rdata)
    );

    always_comb begin
        logic req;
        logic [2:0] cmd;
        logic ok;
        req = 1'b0;
        cmd = 3'd0;
        ok = 1'b0;
        s_d = s_q;
        s_d.start = 1'b0;
        s_d.ack = 1'b0;
        s_d.rst_pin = 1'b1;
        // window timer runs from the rising strobe of the last erase cycle
        if (s_q.win_open) begin
            if (s_q.timer == 32'h0) begin
                s_d.win_open = 1'b0;
            end else begin
                s_d.timer = s_q.timer - 32'h1;
            end
        end
        // busy pin going high means the erase has finished
        if (ready_busy_output && !s_q.win_open && s_q.st == H_IDLE && !s_q.suspended) begin
            s_d.chip_busy = 1'b0;
            s_d.sect_busy = 1'b0;
        end
        req = wb_cyc_i && wb_stb_i && !s_q.ack;
        if (req) begin
            s_d.ack = 1'b1;
            if (wb_we_i && wb_adr_i == 4'h1) begin
                if (wb_sel_i[0]) s_d.addr[7:0] = wb_dat_i[7:0];
                if (wb_sel_i[1]) s_d.addr[15:8] = wb_dat_i[15:8];
                if (wb_sel_i[2]) s_d.addr[20:16] = wb_dat_i[20:16];
            end else if (wb_we_i && wb_adr_i == 4'h0 && wb_sel_i[0]) begin
                cmd = wb_dat_i[2:0];
                // host-side filtering keeps the flash out of undefined states
                if (s_q.st != H_IDLE && s_q.st != H_WIN) begin
                    ok = 1'b0;
                end else if (cmd == 3'd6) begin
                    ok = 1'b1; // hardware reset allowed whenever the host is idle, even if busy, in the window or suspended
                end else if (cmd == 3'd7) begin
                    ok = 1'b1; // a read is no command, status and other banks stay readable
                end else if (s_q.chip_busy) begin
                    ok = 1'b0;
                end else if (s_q.win_open) begin
                    ok = (cmd == 3'd2 || cmd == 3'd3 || cmd == 3'd5);
                end else if (s_q.sect_busy && !s_q.suspended) begin
                    ok = (cmd == 3'd3);
                end else if (s_q.suspended) begin
                    ok = (cmd == 3'd4 || cmd == 3'd7);
                end else begin
                    ok = (cmd == 3'd0 || cmd == 3'd1 || cmd == 3'd7);
                end
                s_d.refused = !ok;
                if (ok && cmd == 3'd6) begin
                    s_d.st = H_RST;
                    s_d.timer = 32'd4;
                    s_d.win_open = 1'b0;
                    s_d.chip_busy = 1'b0;
                    s_d.sect_busy = 1'b0;
                    s_d.suspended = 1'b0;
                end else if (ok) begin
                    s_d.op = (cmd == 3'd7) ? FES_OP_READ : fes_op_t'(cmd);
                    s_d.step = 3'd0;
                    s_d.st = H_ISSUE;
                end
            end
            if (wb_adr_i == 4'h2) begin
                s_d.dat = {24'h0, 1'b0, s_q.refused, s_q.suspended, s_q.win_open,
                           s_q.sect_busy, s_q.chip_busy, ready_busy_output, s_q.st != H_IDLE};
            end else if (wb_adr_i == 4'h1) begin
                s_d.dat = {11'h0, s_q.addr};
            end else if (wb_adr_i == 4'h3) begin
                // data of the last read cycle, at whatever address the addr register held
                s_d.dat = {24'h0, s_q.rdata};
            end else begin
                s_d.dat = 32'h0;
            end
        end
        case (s_q.st)
            H_ISSUE: begin
                s_d.start = 1'b1;
                s_d.st = H_WAIT;
            end
            H_WAIT: begin
                if (bc_done) begin
                    if ((s_q.op == FES_OP_CHIP || s_q.op == FES_OP_SECTOR) && s_q.step != 3'd5) begin
                        s_d.step = s_q.step + 3'd1;
                        s_d.st = H_ISSUE;
                    end else begin
                        s_d.st = H_IDLE;
                        case (s_q.op)
                            FES_OP_CHIP: s_d.chip_busy = 1'b1;
                            FES_OP_SECTOR, FES_OP_ADD_SECTOR: begin
                                s_d.sect_busy = 1'b1;
                                s_d.win_open = 1'b1;
                                // done trails the rising strobe by the recovery cycles
                                s_d.timer = WINDOW_CYC - 32'(`FES_WE_HIGH_CYC + 1);
                            end
                            FES_OP_SUSPEND: begin
                                // wait out the worst-case suspend latency
                                s_d.st = H_SUSP;
                                s_d.win_open = 1'b0;
                                s_d.timer = SUSPEND_CYC;
                            end
                            FES_OP_RESUME: s_d.suspended = 1'b0;
                            FES_OP_RESET: s_d.win_open = 1'b0;
                            default: s_d.rdata = bc_rdata;
                        endcase
                    end
                end
            end
            H_SUSP: begin
                if (s_q.timer == 32'h0) begin
                    s_d.suspended = 1'b1;
                    s_d.st = H_IDLE;
                end else begin
                    s_d.timer = s_q.timer - 32'h1;
                end
            end
            H_RST: begin
                s_d.rst_pin = 1'b0;
                if (s_q.timer == 32'h0) begin
                    s_d.st = H_IDLE;
                end else begin
                    s_d.timer = s_q.timer - 32'h1;
                end
            end
            default: begin
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            s_q <= '0;
            s_q.rst_pin <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    assign wb_dat_o = s_q.dat;
    assign wb_ack_o = s_q.ack;
    assign flash_reset_n = s_q.rst_pin;
endmodule
`default_nettype wire

// ### rtl/fes_cfg.svh
// Purpose: constants for the flash erase sequencing controller
// Assumes: word-mode command addresses, 250 MHz clock
// Notes: times in ns, counts derived from the clock period
`ifndef FES_CFG_SVH
`define FES_CFG_SVH

`define FES_CLK_PERIOD_NS 4
`define FES_UNLOCK1_ADDR 21'h000555
`define FES_UNLOCK2_ADDR 21'h0002aa
`define FES_UNLOCK1_DATA 8'haa
`define FES_UNLOCK2_DATA 8'h55
`define FES_SETUP_DATA 8'h80
`define FES_CHIP_ERASE_DATA 8'h10
`define FES_SECTOR_ERASE_DATA 8'h30
`define FES_SUSPEND_DATA 8'hb0
`define FES_RESUME_DATA 8'h30
`define FES_RESET_DATA 8'hf0
`define FES_WINDOW_NS 50000
`define FES_SUSPEND_NS 35000
`define FES_WINDOW_CYC ((`FES_WINDOW_NS) / (`FES_CLK_PERIOD_NS))
`define FES_SUSPEND_CYC ((`FES_SUSPEND_NS) / (`FES_CLK_PERIOD_NS))
`define FES_WE_LOW_CYC 4
`define FES_WE_HIGH_CYC 4
`define FES_RD_CYC 4
`define FES_SECTOR_LSB 12
`define FES_BANK_LSB 18
`define FES_POLL_BIT 7
`define FES_TOGGLE_BIT 6
`define FES_TIMER_BIT 3
`define FES_ADDR_W 21

`endif

// ### rtl/fes_pkg.sv
// Purpose: types for the flash erase sequencing controller
// Assumes: nothing beyond the cfg header
// Notes: none
package fes_pkg;
    typedef enum logic [2:0] {
        FES_OP_CHIP,
        FES_OP_SECTOR,
        FES_OP_ADD_SECTOR,
        FES_OP_SUSPEND,
        FES_OP_RESUME,
        FES_OP_RESET,
        FES_OP_READ
    } fes_op_t;
endpackage

// ### rtl/fes_bus_cycle.sv
// Purpose: one write or read cycle on the flash parallel bus
// Assumes: flash write and read timing met by fixed cycle counts
// Notes: write data latches on the rising edge of we_n
`timescale 1ns/1ps
`default_nettype none
`include "fes_cfg.svh"
module fes_bus_cycle import fes_pkg::*; (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic start,
    input wire logic write,
    input wire logic [`FES_ADDR_W-1:0] addr,
    input wire logic [7:0] wdata,
    input wire logic [7:0] dq_in,
    output logic [`FES_ADDR_W-1:0] flash_addr,
    output logic [7:0] dq_out,
    output logic dq_oe,
    output logic we_n,
    output logic oe_n,
    output logic ce_n,
    output logic done,
    output logic [7:0] rdata
);
    typedef enum logic [1:0] {BC_IDLE, BC_LOW, BC_HIGH} fes_bc_state_t;
    typedef struct packed {
        fes_bc_state_t st;
        logic [3:0] cnt;
        logic wr;
        logic [`FES_ADDR_W-1:0] a;
        logic [7:0] d;
        logic [7:0] r;
        logic dn;
        logic drv;
        logic wen;
        logic oen;
        logic cen;
    } fes_bc_t;
    fes_bc_t s_q, s_d;

    always_comb begin
        s_d = s_q;
        s_d.dn = 1'b0;
        case (s_q.st)
            BC_IDLE: begin
                if (start) begin
                    s_d.st = BC_LOW;
                    s_d.wr = write;
                    s_d.a = addr;
                    s_d.d = wdata;
                    s_d.cnt = write ? 4'(`FES_WE_LOW_CYC) : 4'(`FES_RD_CYC);
                end
            end
            BC_LOW: begin
                if (s_q.cnt == 4'h1) begin
                    s_d.st = BC_HIGH;
                    s_d.r = dq_in;
                    s_d.cnt = 4'(`FES_WE_HIGH_CYC);
                end else begin
                    s_d.cnt = s_q.cnt - 4'h1;
                end
            end
            default: begin
                // recovery time after the strobe rises
                if (s_q.cnt == 4'h1) begin
                    s_d.st = BC_IDLE;
                    s_d.dn = 1'b1;
                end else begin
                    s_d.cnt = s_q.cnt - 4'h1;
                end
            end
        endcase
        // strobes come from flops so the pins never glitch on a state change
        s_d.drv = s_d.wr && (s_d.st != BC_IDLE);
        s_d.wen = !(s_d.wr && s_d.st == BC_LOW);
        s_d.oen = !(!s_d.wr && s_d.st == BC_LOW);
        s_d.cen = !(s_d.st == BC_LOW);
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            s_q <= '0;
            s_q.wen <= 1'b1;
            s_q.oen <= 1'b1;
            s_q.cen <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    assign flash_addr = s_q.a;
    assign dq_out = s_q.d;
    assign dq_oe = s_q.drv;
    assign we_n = s_q.wen;
    assign oe_n = s_q.oen;
    assign ce_n = s_q.cen;
    assign done = s_q.dn;
    assign rdata = s_q.r;
endmodule
`default_nettype wire

// ### dv/fes_host_props.sv
// Purpose: port checks of the erase sequencing controller
// Assumes: sees fes_host ports only
// Notes: strobe lengths follow the fixed bus cycle counts
`timescale 1ns/1ps
`default_nettype none
`include "fes_cfg.svh"
module fes_host_props import fes_pkg::*; #(
    parameter int unsigned WINDOW_CYC = 50,
    parameter int unsigned SUSPEND_CYC = 20
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic [`FES_ADDR_W-1:0] flash_addr,
    input wire logic [7:0] flash_dq_i,
    input wire logic [7:0] flash_dq_o,
    input wire logic flash_dq_oe,
    input wire logic flash_we_n,
    input wire logic flash_oe_n,
    input wire logic flash_ce_n,
    input wire logic flash_reset_n,
    input wire logic ready_busy_output
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    sequence wr_pulse;
        (!flash_we_n)[*4] ##1 flash_we_n;
    endsequence
    sequence rst_pulse;
        (!flash_reset_n)[*5] ##1 flash_reset_n;
    endsequence
    a_ack_after_req: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("ack missing");
    a_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack too long");
    a_write_pulse_len: assert property ($fell(flash_we_n) |-> wr_pulse)
        else $error("write pulse length");
    a_write_gap_len: assert property ($rose(flash_we_n) |-> flash_we_n[*4])
        else $error("write gap too short");
    a_write_drives_bus: assert property (!flash_we_n |-> flash_dq_oe && !flash_ce_n && flash_oe_n)
        else $error("write without drive");
    a_write_held_still: assert property (!flash_we_n && !$past(flash_we_n)
        |-> $stable(flash_addr) && $stable(flash_dq_o))
        else $error("write data moved");
    a_hw_reset_len: assert property ($fell(flash_reset_n) |-> rst_pulse)
        else $error("reset pulse length");
    a_idle_after_rst: assert property ($rose(rst_n)
        |-> flash_we_n && flash_oe_n && flash_ce_n && flash_reset_n && !wb_ack_o)
        else $error("not idle after reset");
endmodule
bind fes_host fes_host_props #(.WINDOW_CYC(WINDOW_CYC), .SUSPEND_CYC(SUSPEND_CYC)) fes_host_props_i (
    .clk(clk), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .flash_addr(flash_addr), .flash_dq_i(flash_dq_i),
    .flash_dq_o(flash_dq_o), .flash_dq_oe(flash_dq_oe), .flash_we_n(flash_we_n),
    .flash_oe_n(flash_oe_n), .flash_ce_n(flash_ce_n), .flash_reset_n(flash_reset_n),
    .ready_busy_output(ready_busy_output));
`default_nettype wire

// ### dv/fes_flash_model.sv
// Purpose: behavioural flash erase engine facing the host
// Assumes: pins sampled on clk, write taken at we_n rise
// Notes: modes 0 read, 1 window, 2 erasing, 3 suspended, 4 chip, 5 suspending
`timescale 1ns/1ps
`default_nettype none
module fes_flash_model #(
    parameter int WIN = 50,
    parameter int ERASE = 300,
    parameter int SUSP = 10
) (
    input wire logic clk,
    input wire logic [20:0] addr,
    input wire logic [7:0] din,
    input wire logic we_n,
    input wire logic oe_n,
    input wire logic ce_n,
    input wire logic reset_n,
    output logic [7:0] dout = 8'h00,
    output logic rdy = 1'b1
);
    // internal times are parameters so runs stay short
    int mode = 0, step = 0, t = 0, nwr = 0, nadd = 0, mode_q = 0, nwr_q = 0, nadd_q = 0;
    logic we_q = 1'b1, ce_q = 1'b1, tg = 1'b0;
    logic [7:0] bsel = '0;
    logic [511:0] ssel = '0;
    function automatic logic [7:0] rd(input logic [20:0] a);
        if (mode == 3 && ssel[a[20:12]])
            return {1'b1, 4'h0, tg, 2'b00};
        if (mode == 4 || (mode != 0 && mode != 3 && bsel[a[20:18]]))
            return {1'b0, tg, 2'b00, 1'(mode != 1), tg, 2'b00};
        return a[7:0] ^ 8'h5a;
    endfunction
    task automatic add(input logic [20:0] a);
        nadd++;
        ssel[a[20:12]] = 1'b1;
        bsel[a[20:18]] = 1'b1;
        t = WIN;
    endtask
    task automatic cmd(input logic [20:0] a, input logic [7:0] d);
        logic u;
        u = a[10:0] == (step % 3 == 1 ? 11'h2aa : 11'h555);
        nwr++;
        case (mode)
            0: begin
                if (step < 5 && u && d == (step == 2 ? 8'h80 : step % 3 == 1 ? 8'h55 : 8'haa)) begin
                    step++;
                end else if (step == 5 && u && d == 8'h10) begin
                    mode = 4;
                    t = ERASE;
                    step = 0;
                end else if (step == 5 && d == 8'h30) begin
                    mode = 1;
                    step = 0;
                    add(a);
                end else begin
                    step = 0;
                end
            end
            1: begin
                if (d == 8'h30)
                    add(a);
                else if (d == 8'hb0)
                    mode = 3;
                else
                    mode = 0;
            end
            2: begin
                if (d == 8'hb0 && bsel[a[20:18]]) begin
                    mode = 5;
                    t = SUSP;
                end
            end
            3: begin
                if (d == 8'h30 && bsel[a[20:18]]) begin
                    mode = 2;
                    t = ERASE;
                end
            end
            default: ;
        endcase
    endtask
    always @(posedge clk) begin
        if (!reset_n) begin
            mode = 0;
            step = 0;
            t = 0;
        end else if (we_n && !we_q && !ce_q) begin
            cmd(addr, din);
        end
        if (t > 0) begin
            t--;
        end else if (mode == 1) begin
            mode = 2;
            t = ERASE;
        end else if (mode == 5) begin
            mode = 3;
        end else if (mode != 3) begin
            mode = 0;
            bsel = '0;
            ssel = '0;
        end
        tg = ~tg;
        // a released bus must not hold its last value
        dout <= (!oe_n && !ce_n) ? rd(addr) : ~dout;
        rdy <= mode == 0 || mode == 3;
        we_q = we_n;
        ce_q = ce_n;
        mode_q <= mode;
        nwr_q <= nwr;
        nadd_q <= nadd;
    end
endmodule
`default_nettype wire

// ### dv/fes_host_tb.sv
// Purpose: self-checking bench for the erase sequencing controller
// Assumes: flash model on the far side, classic Wishbone master here
// Notes: window and suspend counts shortened by parameter
`timescale 1ns/1ps
`default_nettype none
`include "fes_cfg.svh"
module fes_host_tb import fes_pkg::*;;
    logic clk = 0, rst_n = 0, cyc = 0, stb = 0, we = 0, dq_oe, we_n, oe_n, ce_n, frst_n, rdy, ack;
    logic [3:0] adr = '0;
    logic [31:0] dat = '0, q, st, dat_o, rs = 32'd57442;
    logic [20:0] fa;
    logic [7:0] dq_o, mdq, dq;
    int error_cnt = 0, checks = 0;
    assign dq = dq_oe ? dq_o : mdq;
    fes_host #(.WINDOW_CYC(50), .SUSPEND_CYC(20)) fes_host_i (.clk(clk), .rst_n(rst_n),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf),
        .wb_dat_i(dat), .wb_dat_o(dat_o), .wb_ack_o(ack), .flash_addr(fa), .flash_dq_i(dq),
        .flash_dq_o(dq_o), .flash_dq_oe(dq_oe), .flash_we_n(we_n), .flash_oe_n(oe_n),
        .flash_ce_n(ce_n), .flash_reset_n(frst_n), .ready_busy_output(rdy));
    fes_flash_model fes_flash_model_i (.clk(clk), .addr(fa), .din(dq), .we_n(we_n),
        .oe_n(oe_n), .ce_n(ce_n), .reset_n(frst_n), .dout(mdq), .rdy(rdy));
    initial begin
        forever #2 clk = ~clk;
    end
    function automatic logic [31:0] rnd();
        rs ^= rs << 13;
        rs ^= rs >> 17;
        rs ^= rs << 5;
        return rs;
    endfunction
    function automatic logic [7:0] arr(input logic [20:0] a);
        return a[7:0] ^ 8'h5a;
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
        int n;
        n = 0;
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat <= d;
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 50);
        q = dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk);
        if (n >= 50)
            chk(n, 0);
    endtask
    task automatic wait_st(input int b, input logic v);
        int n;
        n = 0;
        do begin
            wb(0, 4'h2, 0);
            n++;
        end while (q[b] !== v && n < 200);
        chk(q[b], v);
        st = q;
    endtask
    task automatic cmd(input logic [2:0] c, input logic [20:0] a);
        wb(1, 4'h1, {11'h0, a});
        wb(1, 4'h0, {29'h0, c});
        wait_st(0, 1'b0);
    endtask
    task automatic rd_at(input logic [20:0] a);
        cmd(3'h7, a);
        wb(0, 4'h3, 0);
    endtask
    task automatic report_and_stop();
        $display("mismatches %0d of %0d checks", error_cnt, checks);
        if (error_cnt == 0 && checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    initial begin
        repeat (40000) @(posedge clk);
        error_cnt++;
        report_and_stop();
    end
    initial begin
        logic [2:0] b;
        logic [20:0] a, a0;
        int n0;
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        wb(0, 4'h2, 0);
        chk(q[6:0], 7'h02);
        repeat (3) begin
            a = 21'(rnd());
            wb(1, 4'h1, {11'h0, a});
            wb(0, 4'h1, 0);
            chk(q[20:0], a);
        end
        wb(0, 4'h9, 0);
        n0 = fes_flash_model_i.nwr_q;
        cmd(3'h0, 21'h0);
        chk(fes_flash_model_i.nwr_q - n0, 6);
        chk(fes_flash_model_i.mode_q, 4);
        chk(st[2:1], 2'b10);
        cmd(3'h3, 21'h0);
        chk(st[6], 1);
        chk(fes_flash_model_i.nwr_q - n0, 6);
        wait_st(2, 1'b0);
        chk(fes_flash_model_i.mode_q, 0);
        // all sectors in one bank, so the other bank stays plain array
        b = 3'(rnd());
        a0 = {b, 6'(rnd()), 12'h000};
        n0 = fes_flash_model_i.nwr_q;
        cmd(3'h1, a0);
        chk(st[4], 1);
        for (int i = 0; i < 2; i++)
            cmd(3'h2, {b, 6'(rnd()), 12'h000});
        chk(fes_flash_model_i.nadd_q, 3);
        chk(fes_flash_model_i.nwr_q - n0, 8);
        cmd(3'h3, {b, 18'h0});
        chk(fes_flash_model_i.mode_q, 3);
        chk(st[5], 1);
        a = {~b, 18'(rnd())};
        rd_at(a);
        chk(q[7:0], arr(a));
        rd_at(a0);
        chk(q[7], 1);
        cmd(3'h4, {b, 18'h0});
        chk(st[5], 0);
        chk(fes_flash_model_i.mode_q, 2);
        a = {~b, 18'(rnd())};
        rd_at(a);
        chk(q[7:0], arr(a));
        rd_at(a0);
        chk(q[7], 0);
        cmd(3'h2, a0);
        chk(st[6], 1);
        cmd(3'h3, {b, 18'h0});
        wait_st(5, 1'b1);
        cmd(3'h6, 21'h0);
        wait_st(1, 1'b1);
        chk(fes_flash_model_i.mode_q, 0);
        // window left by the software reset code, chip erase code refused
        cmd(3'h1, a0);
        cmd(3'h0, 21'h0);
        chk(st[6], 1);
        cmd(3'h5, 21'h0);
        chk(fes_flash_model_i.mode_q, 0);
        wait_st(3, 1'b0);
        report_and_stop();
    end
endmodule
`default_nettype wire
